// [design/emat_pkg.sv]
// Operation
// - one decode clock before wait counting
// - read start: address, high direction, size, strobe
// - write start: direction low with address, strobe
// - capture address, direction, size at second clock
// - auto ack selects programmed wait count
// - master negates strobe, samples acknowledge
// - master drives write data in second clock
// - zero wait: acknowledge at third clock start
// - first drive: negated if waits, else asserted
// - master waits until acknowledge seen asserted
// - read: latch data on acknowledge, end
// - write: hold data while acknowledge negated
// - negate acknowledge next clock, then release
// - master releases data after write acknowledge
// - bursts also get the extra decode clock
// - master advances address after each acknowledge but the last
// - auto ack after programmed wait count
// - device never drives address for default memory
package emat_pkg;
    localparam int ADDR_W = 28;
    localparam int DATA_W = 32;
    localparam int WS_W = 4;
    localparam int BEAT_W = 5;
    localparam int PW_W = 2;

    // transfer size codes on the width lines
    localparam logic [1:0] WIDTH_LONG = 2'h0;
    localparam logic [1:0] WIDTH_BYTE = 2'h1;
    localparam logic [1:0] WIDTH_WORD = 2'h2;
    localparam logic [1:0] WIDTH_LINE = 2'h3;

    // port size codes
    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [1:0] PORT_8 = 2'h1;
    localparam logic [1:0] PORT_16 = 2'h2;

    localparam logic [WS_W-1:0] WS_ZERO = 4'h0;
    localparam logic [WS_W-1:0] WS_ONE = 4'h1;
    localparam logic [BEAT_W-1:0] BEAT_ONE = 5'h01;
    localparam logic [BEAT_W-1:0] BEAT_ZERO = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 28'h0000000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
    localparam logic [1:0] WIDTH_RST = 2'h0;

    typedef logic [ADDR_W-1:0] emat_addr_t;
    typedef logic [DATA_W-1:0] emat_data_t;

    // bytes moved by one acknowledge on a port
    function automatic logic [2:0] emat_port_bytes(input logic [1:0] port);
        if (port == PORT_8) begin
            return 3'h1;
        end else if (port == PORT_16) begin
            return 3'h2;
        end else begin
            return 3'h4;
        end
    endfunction

    // acknowledges needed for one transfer
    function automatic logic [BEAT_W-1:0] emat_beats(input logic [1:0] width,
                                                   input logic [1:0] port);
        logic [4:0] bytes;
        logic [2:0] pb;
        bytes = 5'h04;
        pb = emat_port_bytes(port);
        if (width == WIDTH_BYTE) begin
            bytes = 5'h01;
        end else if (width == WIDTH_WORD) begin
            bytes = 5'h02;
        end else if (width == WIDTH_LINE) begin
            bytes = 5'h10;
        end
        if ({2'h0, pb} >= bytes) begin
            return BEAT_ONE;
        end else if (pb == 3'h1) begin
            return bytes;
        end else if (pb == 3'h2) begin
            return {1'b0, bytes[4:1]};
        end else begin
            return {2'h0, bytes[4:2]};
        end
    endfunction

    // read data from the top lane of a port, shifted in at the low end
    function automatic emat_data_t emat_merge(input emat_data_t acc, input emat_data_t bus,
                                              input logic [1:0] port);
        if (port == PORT_8) begin
            return {acc[23:0], bus[31:24]};
        end else if (port == PORT_16) begin
            return {acc[15:0], bus[31:16]};
        end else begin
            return bus;
        end
    endfunction
endpackage

// [design/emat_bus_if.sv]
`timescale 1ns/10ps
// shared bus between the watching device and the external master
interface emat_bus_if;
    import emat_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic rd_wr;
    logic [1:0] xfer_width;
    logic xfer_begin_strobe_n;
    logic [DATA_W-1:0] wdata;
    logic wdata_oe_n;
    logic [DATA_W-1:0] slave_data;
    logic [DATA_W-1:0] data_bus;
    logic ack_drv_n;
    logic ack_oe_n;
    logic xfer_ack_n;
    logic dev_addr_oe_n;

    // pulled-up acknowledge line, data bus resolved from enables
    assign xfer_ack_n = ack_oe_n ? 1'b1 : ack_drv_n;
    assign data_bus = wdata_oe_n ? slave_data : wdata;

    modport device (
        input addr, rd_wr, xfer_width, xfer_begin_strobe_n,
        output ack_drv_n, ack_oe_n, dev_addr_oe_n
    );
    modport master (
        output addr, rd_wr, xfer_width, xfer_begin_strobe_n, wdata, wdata_oe_n,
        input xfer_ack_n, data_bus
    );
endinterface

// [design/emat_device.sv]
`timescale 1ns/10ps
// **************************************************
// default memory acknowledge for external masters
// **************************************************
module emat_device (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    emat_bus_if.device bus,
    input wire logic ext_master_auto_ack_in,
    input wire logic [emat_pkg::WS_W-1:0] wait_count_field_in,
    input wire logic [emat_pkg::PW_W-1:0] port_width_in,
    output logic [emat_pkg::ADDR_W-1:0] captured_addr_out,
    output logic captured_read_out,
    output logic [1:0] captured_width_out,
    output logic busy_out,
    output logic ack_pulse_out
);
    import emat_pkg::*;

    // **************************************************
    // state and registers
    // **************************************************
    typedef enum logic [4:0] {
        dev_idle = 5'h01,
        dev_decode = 5'h02,
        dev_count = 5'h04,
        dev_ack = 5'h08,
        dev_negate = 5'h10
    } emat_dev_state_e;

    // sequencer state
    emat_dev_state_e state;
    emat_dev_state_e next_state;

    // wait states left before the next acknowledge
    logic [WS_W-1:0] wait_cnt;
    logic [WS_W-1:0] next_wait_cnt;

    // acknowledges left in this transfer
    logic [BEAT_W-1:0] beats_left;
    logic [BEAT_W-1:0] next_beats_left;

    // pin drive flops, all active low
    logic ack_drv_n;
    logic ack_oe_n;
    logic dev_addr_oe_n;

    // **************************************************
    // decode wires
    // **************************************************
    wire logic strobe_seen;
    wire logic ws_is_zero;
    wire logic cnt_done;
    wire logic last_beat;

    // next levels for the pin and status flops
    wire logic next_ack_drv_n;
    wire logic next_ack_oe_n;
    wire logic next_busy;
    wire logic [BEAT_W-1:0] decoded_beats;

    // strobe only counts when nothing is in flight
    assign strobe_seen = !bus.xfer_begin_strobe_n && (state == dev_idle);
    assign ws_is_zero = (wait_count_field_in == WS_ZERO);
    assign cnt_done = (wait_cnt == WS_ONE);
    assign last_beat = (beats_left == BEAT_ONE);
    assign decoded_beats = emat_beats(captured_width_out, port_width_in);

    // line level follows the next state, so it comes from a flop
    assign next_ack_drv_n = (next_state != dev_ack);
    assign next_ack_oe_n = (next_state == dev_idle) || (next_state == dev_decode);
    assign next_busy = (next_state != dev_idle);

    // **************************************************
    // next state
    // **************************************************
    always_comb begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        next_beats_left = beats_left;
        case (state)
            dev_idle: begin
                // wait for a start strobe
                if (strobe_seen) begin
                    next_state = dev_decode;
                end
            end
            dev_decode: begin
                // one whole clock spent on decode before counting
                next_beats_left = decoded_beats;
                if (!ext_master_auto_ack_in) begin
                    next_state = dev_idle;
                end else if (ws_is_zero) begin
                    next_state = dev_ack;
                end else begin
                    next_state = dev_count;
                    next_wait_cnt = wait_count_field_in;
                end
            end
            dev_count: begin
                // count down once per clock, ack follows a count of one
                if (cnt_done) begin
                    next_state = dev_ack;
                    next_wait_cnt = WS_ZERO;
                end else begin
                    next_wait_cnt = wait_cnt - WS_ONE;
                end
            end
            dev_ack: begin
                // acknowledge asserted for this beat
                if (last_beat) begin
                    next_state = dev_negate;
                    next_beats_left = BEAT_ZERO;
                end else begin
                    // further burst beats reuse the same wait count
                    next_beats_left = beats_left - BEAT_ONE;
                    if (!ws_is_zero) begin
                        next_state = dev_count;
                        next_wait_cnt = wait_count_field_in;
                    end
                end
            end
            dev_negate: begin
                // one cycle driven negated, then released
                next_state = dev_idle;
            end
            default: begin
                next_state = dev_idle;
            end
        endcase
    end

    // **************************************************
    // registers
    // **************************************************
    // sequencer state
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= dev_idle;
            wait_cnt <= WS_ZERO;
            beats_left <= BEAT_ZERO;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            beats_left <= next_beats_left;
        end
    end

    // **************************************************
    // master capture
    // **************************************************
    // capture of master address, direction and size
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            captured_addr_out <= ADDR_ZERO;
            captured_read_out <= 1'b0;
            captured_width_out <= WIDTH_RST;
        end else if (strobe_seen) begin
            captured_addr_out <= bus.addr;
            captured_read_out <= bus.rd_wr;
            captured_width_out <= bus.xfer_width;
        end
    end

    // **************************************************
    // acknowledge pin and status flags
    // **************************************************
    // acknowledge level and drive enable
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_drv_n <= 1'b1;
            ack_oe_n <= 1'b1;
        end else begin
            ack_drv_n <= next_ack_drv_n;
            ack_oe_n <= next_ack_oe_n;
        end
    end

    // busy level and acknowledge marker for the user side
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
            ack_pulse_out <= 1'b0;
        end else begin
            busy_out <= next_busy;
            ack_pulse_out <= !next_ack_drv_n;
        end
    end

    // **************************************************
    // address pins
    // **************************************************
    // address pins are never driven for default memory
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dev_addr_oe_n <= 1'b1;
        end else begin
            dev_addr_oe_n <= 1'b1;
        end
    end

    // **************************************************
    // bus side
    // **************************************************
    assign bus.ack_drv_n = ack_drv_n;
    assign bus.ack_oe_n = ack_oe_n;
    assign bus.dev_addr_oe_n = dev_addr_oe_n;
endmodule

// [design/emat_master.sv]
`timescale 1ns/10ps
// **************************************************
// external bus master end
// **************************************************
module emat_master (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    emat_bus_if.master bus,
    input wire logic req_in,
    input wire logic req_read_in,
    input wire logic [emat_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [1:0] req_width_in,
    input wire logic [emat_pkg::DATA_W-1:0] req_wdata_in,
    input wire logic [emat_pkg::PW_W-1:0] port_width_in,
    output logic busy_out,
    output logic done_out,
    output logic [emat_pkg::DATA_W-1:0] rdata_out
);
    import emat_pkg::*;

    typedef enum logic [3:0] {
        mst_idle = 4'h1,
        mst_start = 4'h2,
        mst_wait = 4'h4,
        mst_release = 4'h8
    } emat_mst_state_e;

    emat_mst_state_e state;
    logic [ADDR_W-1:0] addr;
    logic rd_wr;
    logic [1:0] width;
    logic strobe_n;
    logic [DATA_W-1:0] wdata;
    logic wdata_oe_n;
    logic [BEAT_W-1:0] beats_left;

    // **************************************************
    // decode wires
    // **************************************************
    wire logic ack_seen;
    wire logic last_beat;
    wire logic [ADDR_W-1:0] addr_step;

    assign ack_seen = (state == mst_wait) && !bus.xfer_ack_n;
    assign last_beat = (beats_left == BEAT_ONE);
    assign addr_step = {25'h0000000, emat_port_bytes(port_width_in)};

    // **************************************************
    // sequencer
    // **************************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= mst_idle;
            addr <= ADDR_ZERO;
            rd_wr <= 1'b1;
            width <= WIDTH_RST;
            strobe_n <= 1'b1;
            wdata <= DATA_ZERO;
            wdata_oe_n <= 1'b1;
            beats_left <= BEAT_ZERO;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= DATA_ZERO;
        end else begin
            done_out <= 1'b0;
            case (state)
                mst_idle: begin
                    if (req_in) begin
                        // first clock: address, direction, size, strobe
                        state <= mst_start;
                        addr <= req_addr_in;
                        rd_wr <= req_read_in;
                        width <= req_width_in;
                        strobe_n <= 1'b0;
                        wdata <= req_wdata_in;
                        beats_left <= emat_beats(req_width_in, port_width_in);
                        busy_out <= 1'b1;
                        rdata_out <= DATA_ZERO;
                    end
                end
                mst_start: begin
                    state <= mst_wait;
                    strobe_n <= 1'b1;
                    wdata_oe_n <= rd_wr;
                end
                mst_wait: begin
                    if (ack_seen) begin
                        if (rd_wr) begin
                            rdata_out <= emat_merge(rdata_out, bus.data_bus,
                                                    port_width_in);
                        end
                        if (last_beat) begin
                            state <= mst_release;
                            wdata_oe_n <= 1'b1;
                            done_out <= 1'b1;
                        end else begin
                            beats_left <= beats_left - BEAT_ONE;
                            addr <= addr + addr_step;
                        end
                    end else begin
                        wdata_oe_n <= rd_wr;
                    end
                end
                mst_release: begin
                    state <= mst_idle;
                    busy_out <= 1'b0;
                end
                default: begin
                    state <= mst_idle;
                end
            endcase
        end
    end

    // **************************************************
    // bus side
    // **************************************************
    assign bus.addr = addr;
    assign bus.rd_wr = rd_wr;
    assign bus.xfer_width = width;
    assign bus.xfer_begin_strobe_n = strobe_n;
    assign bus.wdata = wdata;
    assign bus.wdata_oe_n = wdata_oe_n;
endmodule

// [tb/emat_monitor.sv]
`timescale 1ns/10ps
// ****************************************
// bus checks beside the shared interface
// ****************************************
module emat_monitor (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic rd_wr,
    input wire logic xfer_begin_strobe_n,
    input wire logic [emat_pkg::DATA_W-1:0] wdata,
    input wire logic wdata_oe_n,
    input wire logic xfer_ack_n,
    input wire logic ack_oe_n,
    input wire logic dev_addr_oe_n,
    input wire logic ext_master_auto_ack_in,
    input wire logic [emat_pkg::WS_W-1:0] wait_count_field_in
);
    import emat_pkg::*;
    logic [4:0] neg_run;
    // start decode and driven-negated acknowledge
    wire start_auto = !xfer_begin_strobe_n && ext_master_auto_ack_in;
    wire ack_neg_drv = !ack_oe_n && xfer_ack_n;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // cycles of acknowledge driven negated, saturating
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            neg_run <= 5'h00;
        end else if (ack_neg_drv && neg_run != 5'h1f) begin
            neg_run <= neg_run + 5'h01;
        end else if (!ack_neg_drv) begin
            neg_run <= 5'h00;
        end
    end
    AST_NO_ADDR_DRIVE: assert property (dev_addr_oe_n)
        else $error("device drove the address bus");
    AST_STROBE_ONE: assert property (!xfer_begin_strobe_n |=> xfer_begin_strobe_n)
        else $error("start strobe longer than one cycle");
    AST_DECODE_GAP: assert property (start_auto |=> ack_oe_n ##1 !ack_oe_n)
        else $error("acknowledge not driven after one decode cycle");
    AST_ZERO_WAIT: assert property ((start_auto && wait_count_field_in == WS_ZERO)
        |-> ##2 !xfer_ack_n) else $error("zero wait acknowledge late");
    AST_FIRST_NEG: assert property ((start_auto && wait_count_field_in != WS_ZERO)
        |-> ##2 ack_neg_drv) else $error("first drive not negated");
    AST_WAIT_COUNT: assert property ((!xfer_ack_n && neg_run != 5'h00)
        |-> neg_run == {1'b0, wait_count_field_in}) else $error("wrong wait count");
    AST_NEG_RELEASE: assert property ($rose(ack_oe_n)
        |-> $past(ack_neg_drv) && !$past(xfer_ack_n, 2)) else $error("bad release");
    AST_NO_AUTO: assert property ((!xfer_begin_strobe_n && !ext_master_auto_ack_in)
        |=> ack_oe_n [*4]) else $error("acknowledge driven without auto ack");
    AST_WDATA_HOLD: assert property ((!wdata_oe_n && xfer_ack_n && !rd_wr)
        |=> $stable(wdata) && !wdata_oe_n) else $error("write data moved during wait");
    AST_WDATA_RELEASE: assert property ($rose(ack_oe_n) |-> $past(wdata_oe_n))
        else $error("write data not released");
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("ERROR at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module testbench;
    import emat_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic auto_ack = 1'b1;
    logic [WS_W-1:0] wait_cnt = WS_ZERO;
    logic [1:0] port_w = PORT_32;
    logic req = 1'b0;
    logic req_read = 1'b1;
    emat_addr_t req_addr = ADDR_ZERO;
    logic [1:0] req_width = WIDTH_LONG;
    emat_data_t req_wdata = 32'h5ac3e1f0;
    emat_addr_t cap_addr;
    logic cap_read;
    logic [1:0] cap_width;
    logic ack_pulse;
    logic d_busy;
    logic m_busy;
    logic m_done;
    emat_data_t rdata;
    int error_cnt = 0;
    int checks_done = 0;
    int cycle_cnt = 0;
    emat_bus_if bus_if ();
    // memory returns the low address byte on the top lane
    assign bus_if.slave_data = {bus_if.addr[7:0], 24'h000000};
    emat_device i_emat_device (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .bus(bus_if),
        .ext_master_auto_ack_in(auto_ack), .wait_count_field_in(wait_cnt),
        .port_width_in(port_w), .captured_addr_out(cap_addr), .captured_read_out(cap_read),
        .captured_width_out(cap_width), .busy_out(d_busy), .ack_pulse_out(ack_pulse));
    emat_master i_emat_master (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .bus(bus_if),
        .req_in(req), .req_read_in(req_read), .req_addr_in(req_addr), .req_width_in(req_width),
        .req_wdata_in(req_wdata), .port_width_in(port_w), .busy_out(m_busy),
        .done_out(m_done), .rdata_out(rdata));
    emat_monitor i_emat_monitor (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .rd_wr(bus_if.rd_wr), .xfer_begin_strobe_n(bus_if.xfer_begin_strobe_n),
        .wdata(bus_if.wdata), .wdata_oe_n(bus_if.wdata_oe_n), .xfer_ack_n(bus_if.xfer_ack_n),
        .ack_oe_n(bus_if.ack_oe_n), .dev_addr_oe_n(bus_if.dev_addr_oe_n),
        .ext_master_auto_ack_in(auto_ack), .wait_count_field_in(wait_cnt));
    // ****************************************
    // clock and hang guard
    // ****************************************
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cycle_cnt++;
        if (cycle_cnt == 4000) begin
            error_cnt++;
            $display("ERROR at %0t: timeout", $time);
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // one transfer, judged on timing, acks and data
    // ****************************************
    task automatic xfer(input logic rd, input emat_addr_t a, input logic [1:0] w,
                        input logic [1:0] p, input int ws, input int beats, input emat_data_t exp);
        int cyc;
        int acks;
        acks = 0;
        @(negedge sys_clk_in);
        wait_cnt = ws[WS_W-1:0];
        port_w = p;
        req_read = rd;
        req_addr = a;
        req_width = w;
        req = 1'b1;
        @(negedge sys_clk_in);
        req = 1'b0;
        cyc = 1;
        while (m_done !== 1'b1 && cyc < 300) begin
            if (ack_pulse === 1'b1) begin
                acks++;
                if (acks == 1) `CHK(cyc, 3 + ws)
                if (!rd) `CHK(bus_if.data_bus, req_wdata)
            end
            @(negedge sys_clk_in);
            cyc++;
        end
        `CHK(bus_if.ack_oe_n, 1'b0)
        `CHK(bus_if.xfer_ack_n, 1'b1)
        `CHK(bus_if.wdata_oe_n, 1'b1)
        `CHK(d_busy, 1'b1)
        `CHK(cyc, 3 + beats * (1 + ws))
        `CHK(acks, beats)
        `CHK(cap_addr, a)
        `CHK(cap_read, rd)
        `CHK(cap_width, w)
        if (rd) `CHK(rdata, exp)
        repeat (2) @(negedge sys_clk_in);
        `CHK(bus_if.ack_oe_n, 1'b1)
        `CHK(d_busy, 1'b0)
        `CHK(bus_if.wdata_oe_n, 1'b1)
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_single();
        xfer(1'b1, 28'h0000140, WIDTH_LONG, PORT_32, 0, 1, 32'h40000000);
        xfer(1'b1, 28'h0000184, WIDTH_LONG, PORT_32, 3, 1, 32'h84000000);
        xfer(1'b0, 28'h0000200, WIDTH_LONG, PORT_32, 2, 1, DATA_ZERO);
        xfer(1'b0, 28'h0000204, WIDTH_LONG, PORT_32, 0, 1, DATA_ZERO);
        $display("single transfers finished");
    endtask
    task automatic test_widths();
        xfer(1'b1, 28'h0000301, WIDTH_BYTE, PORT_32, 1, 1, 32'h01000000);
        xfer(1'b1, 28'h0000302, WIDTH_WORD, PORT_32, 0, 1, 32'h02000000);
        xfer(1'b1, 28'h0000310, WIDTH_LINE, PORT_32, 0, 4, 32'h1c000000);
        $display("size codes finished");
    endtask
    task automatic test_burst();
        xfer(1'b1, 28'h0000420, WIDTH_LONG, PORT_8, 0, 4, 32'h20212223);
        xfer(1'b1, 28'h0000440, WIDTH_LONG, PORT_16, 1, 2, 32'h40004200);
        xfer(1'b0, 28'h0000480, WIDTH_LONG, PORT_16, 1, 2, DATA_ZERO);
        $display("burst transfers finished");
    endtask
    task automatic test_no_auto();
        @(negedge sys_clk_in);
        auto_ack = 1'b0;
        req_read = 1'b1;
        req = 1'b1;
        @(negedge sys_clk_in);
        req = 1'b0;
        repeat (8) begin
            @(negedge sys_clk_in);
            `CHK(bus_if.xfer_ack_n, 1'b1)
        end
        `CHK(m_busy, 1'b1)
        `CHK(d_busy, 1'b0)
        rst_n_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        auto_ack = 1'b1;
        @(negedge sys_clk_in);
        `CHK(m_busy, 1'b0)
        `CHK(bus_if.ack_oe_n, 1'b1)
        xfer(1'b1, 28'h0000508, WIDTH_LONG, PORT_32, 0, 1, 32'h08000000);
        $display("no auto ack and reset finished");
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        test_single();
        test_widths();
        test_burst();
        test_no_auto();
        wrap_up();
    end
endmodule
